// >>> common/ctw_pkg.sv
// Constants for the core timer, watchdog and reset sequencer.
// Assumes a 32-bit Avalon-MM slave with byte addresses; each
// register index below sits at byte address index * 4.
package ctw_pkg;

  // Register indices (byte address is index * 4)
  localparam logic [13:0] CTW_IDX_CSR = 14'h0008;
  localparam logic [13:0] CTW_IDX_CNT = 14'h0009;
  localparam logic [13:0] CTW_IDX_MST = 14'h000a;
  localparam logic [13:0] CTW_IDX_WDS = 14'h3ff0;

  // Field positions of timer_control_status
  localparam int CTW_B_OVF = 7;
  localparam int CTW_B_PER = 6;
  localparam int CTW_B_OVFE = 5;
  localparam int CTW_B_PERE = 4;
  localparam int CTW_B_OVFC = 3;
  localparam int CTW_B_PERC = 2;
  localparam int CTW_B_RATE = 0;

  // Rate select reset value and fixed service read data
  localparam logic [1:0] CTW_RATE_RST = 2'h3;
  localparam logic [7:0] CTW_SERVICE_DATA = 8'h00;

  // Stabilisation time, in bus clock cycles, and last count
  localparam int CTW_STAB_CYC = 4064;
  localparam logic [11:0] CTW_STAB_LAST = 12'(CTW_STAB_CYC - 1);

  // Timer chain layout
  localparam int CTW_CHAIN_W = 15;
  localparam int CTW_CNT_LSB = 2;
  localparam int CTW_OVF_MSB = 9;
  localparam int CTW_TAP_MSB = 11;
  localparam int CTW_WD_W = 3;

  // Operating modes of the device
  typedef enum logic [1:0] {
    CTW_RUN,
    CTW_WAIT,
    CTW_STOP,
    CTW_WAKE
  } ctw_mode_t;

endpackage

// >>> core/ctw_core_timer.sv
// Core timer chain, watchdog, reset combiner and low-power modes.
// Assumes a CPU on the same clock giving stop/wait requests and
// fetch addresses, and pins for reset, low-power reset and irq.
//
// Functional notes
// RQ1 - Hold reset 4064 cycles after power-up
// RQ2 - Reset stays while other sources active
// RQ3 - Watchdog time-out resets the whole controller
// RQ4 - Writing zero to bit 0 services watchdog
// RQ5 - Service location reads return fixed user data
// RQ6 - Watchdog keeps counting in wait mode
// RQ7 - Watchdog presence is a build option
// RQ8 - Stop mode freezes the watchdog count
// RQ9 - Reset exit from stop reruns stabilisation
// RQ10 - Interrupt exit counts the 4064 cycles
// RQ11 - Software should service watchdog before stop
// RQ12 - Fetch from 0000-001F raises illegal reset
// RQ13 - Stop clears timer requests, prescaler, mask
// RQ14 - Only interrupt or reset leaves stop
// RQ15 - Wait keeps timer, clears mask, irq exits
// RQ16 - Low-power reset halts, then stabilises
// RQ17 - Divide by four clocks readable 8-bit counter
// RQ18 - Overflow flag sets on counter wrap
// RQ19 - Periodic flag sets on selected tap
// RQ20 - Watchdog divides periodic tap by eight
// RQ21 - Overflow flag cleared only by clear bit; the code also clears it on stop entry
// RQ22 - Periodic flag cleared only by clear bit; the code also clears it on stop entry
// RQ23 - Flag with enable requests interrupt
// RQ24 - Rate select picks tap, resets to 11
// RQ25 - Service clears only final divide stage
// RQ26 - External reset clears whole counter chain
// RQ27 - All reset sources form one reset
`timescale 1ns/100ps

module ctw_core_timer #(
  parameter bit P_WDOG_EN = 1'b1  // Watchdog built in
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ext_resetn,
  input wire logic i_low_power_reset_input_n,
  input wire logic i_ext_irq_n,
  input wire logic i_stop_req,
  input wire logic i_wait_req,
  input wire logic i_fetch_valid,
  input wire logic [13:0] i_fetch_addr,
  input wire logic [15:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_rst_n,
  output logic o_cpu_hold,
  output logic o_clk_halt,
  output logic o_timer_irq,
  output logic o_imask_clear,
  output logic o_stop,
  output logic o_wait
);

  //////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] sync1_r;  // First stage, read only by sync2_r
  logic [2:0] sync2_r;  // Second stage, safe to use
  logic [2:0] sync1_nxt;
  logic [2:0] sync2_nxt;
  logic ext_rst;   // External reset asserted
  logic lp_rst;    // Low-power reset asserted
  logic ext_irq;   // External interrupt asserted

  // Next values: shift the pin levels through two stages
  always_comb begin
    sync1_nxt = {i_ext_resetn, i_low_power_reset_input_n,
                 i_ext_irq_n};
    sync2_nxt = sync1_r;
  end

  // Pins idle high, so reset loads the inactive level
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  assign ext_rst = ~sync2_r[2];
  assign lp_rst = ~sync2_r[1];
  assign ext_irq = ~sync2_r[0];

  //////////////////////////////////////////////////////////////////
  // Reset combiner and mode sequencer

  ctw_pkg::ctw_mode_t mode_r;  // Current operating mode
  ctw_pkg::ctw_mode_t mode_nxt;
  logic [11:0] stab_cnt_r;     // Stabilisation cycle count
  logic [11:0] stab_cnt_nxt;
  logic stab_r;                // Reset-held stabilisation busy
  logic stab_nxt;
  logic int_rst_r;             // One-cycle internal reset cause
  logic int_rst_nxt;
  logic rst_n_r;               // Combined reset, active low
  logic rst_n_nxt;
  logic imclr_r;               // Interrupt mask clear pulse
  logic imclr_nxt;
  logic wd_to;                 // Watchdog time-out event
  logic illegal;               // Illegal fetch event
  logic freeze;                // Oscillator halted
  logic stab_end;              // Last stabilisation cycle

  // Fetch from the I/O page is illegal (see RQ12)
  assign illegal = i_fetch_valid & (i_fetch_addr[13:5] == 9'h000);
  assign stab_end = stab_cnt_r == ctw_pkg::CTW_STAB_LAST;

  // Next mode and reset state
  always_comb begin
    mode_nxt = mode_r;
    stab_cnt_nxt = stab_cnt_r;
    stab_nxt = stab_r;
    imclr_nxt = 1'b0;
    // Watchdog and illegal fetch reset the controller (see RQ3)
    int_rst_nxt = wd_to | illegal;
    case (mode_r)
      ctw_pkg::CTW_RUN: begin
        // Reset has priority over entering a low-power mode
        if (!rst_n_r || ext_rst || int_rst_r) begin
          mode_nxt = ctw_pkg::CTW_RUN;
        end else if (i_stop_req) begin
          mode_nxt = ctw_pkg::CTW_STOP;
          imclr_nxt = 1'b1;  // see RQ13
        end else if (i_wait_req) begin
          mode_nxt = ctw_pkg::CTW_WAIT;
          imclr_nxt = 1'b1;  // see RQ15
        end
      end
      ctw_pkg::CTW_WAIT: begin
        // Any interrupt or reset ends wait (see RQ15)
        if (o_timer_irq || ext_irq || ext_rst || int_rst_r) begin
          mode_nxt = ctw_pkg::CTW_RUN;
        end
      end
      ctw_pkg::CTW_STOP: begin
        // Only reset or external irq leave stop (see RQ14)
        if (ext_rst) begin
          mode_nxt = ctw_pkg::CTW_RUN;
          stab_nxt = 1'b1;  // see RQ9
          stab_cnt_nxt = 12'h000;
        end else if (ext_irq) begin
          mode_nxt = ctw_pkg::CTW_WAKE;  // see RQ10
          stab_cnt_nxt = 12'h000;
        end
      end
      ctw_pkg::CTW_WAKE: begin
        // Timer chain runs while the CPU waits (see RQ10)
        stab_cnt_nxt = 12'(stab_cnt_r + 12'h001);
        if (stab_end) begin
          mode_nxt = ctw_pkg::CTW_RUN;
        end
      end
      default: begin
        mode_nxt = ctw_pkg::CTW_RUN;
      end
    endcase
    // Reset-held stabilisation count (see RQ1)
    if (stab_r) begin
      stab_cnt_nxt = 12'(stab_cnt_r + 12'h001);
      if (stab_end) begin
        stab_nxt = 1'b0;
      end
    end
    // Low-power reset holds everything and restarts (see RQ16)
    if (lp_rst) begin
      mode_nxt = ctw_pkg::CTW_RUN;
      stab_nxt = 1'b1;
      stab_cnt_nxt = 12'h000;
      int_rst_nxt = 1'b0;
    end
    // Reset stays until every source ends (see RQ2, RQ27)
    // Watchdog and fetch causes hold reset for one cycle only; that
    // cycle is enough, since the timer flops clear on rst_n_r low
    rst_n_nxt = ~(stab_nxt | lp_rst | ext_rst | int_rst_nxt);
  end

  // Power-up starts the stabilisation with reset held
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      mode_r <= ctw_pkg::CTW_RUN;
      stab_cnt_r <= 12'h000;
      stab_r <= 1'b1;  // see RQ1
      int_rst_r <= 1'b0;
      rst_n_r <= 1'b0;
      imclr_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      stab_cnt_r <= stab_cnt_nxt;
      stab_r <= stab_nxt;
      int_rst_r <= int_rst_nxt;
      rst_n_r <= rst_n_nxt;
      imclr_r <= imclr_nxt;
    end
  end

  // Clocks stop in stop mode and in low-power reset (see RQ8)
  assign freeze = (mode_r == ctw_pkg::CTW_STOP) | lp_rst;
  assign o_rst_n = rst_n_r;
  assign o_cpu_hold = mode_r == ctw_pkg::CTW_WAKE;
  assign o_clk_halt = freeze;
  assign o_imask_clear = imclr_r;
  assign o_stop = mode_r == ctw_pkg::CTW_STOP;
  assign o_wait = mode_r == ctw_pkg::CTW_WAIT;

  // Timer state, declared here because the bus read mux below
  // shows it; the logic that updates it follows the bus section
  logic [ctw_pkg::CTW_CHAIN_W-1:0] chain_r; // Ripple chain
  logic [ctw_pkg::CTW_CHAIN_W-1:0] chain_nxt;
  logic [ctw_pkg::CTW_WD_W-1:0] wd_r; // Final divide by 8
  logic [ctw_pkg::CTW_WD_W-1:0] wd_nxt;
  logic ovf_r; // Overflow flag
  logic ovf_nxt;
  logic per_r; // Periodic flag
  logic per_nxt;
  logic ovfe_r; // Overflow interrupt enable
  logic ovfe_nxt;
  logic pere_r; // Periodic interrupt enable
  logic pere_nxt;
  logic [1:0] rate_r; // Periodic rate select
  logic [1:0] rate_nxt;

  //////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle on every access
  // Read data is a snapshot taken at the edge after the request
  // rises; the live counter may have moved on by the answer edge.

  logic ack_r;           // Second cycle of an access
  logic ack_nxt;
  logic [31:0] rdata_r;  // Read data, valid with the answer
  logic [31:0] rdata_nxt;
  logic wr_go;           // Write takes effect this edge
  logic sel_csr;
  logic sel_cnt;
  logic sel_mst;
  logic sel_wds;

  assign sel_csr = i_address == {ctw_pkg::CTW_IDX_CSR, 2'b00};
  assign sel_cnt = i_address == {ctw_pkg::CTW_IDX_CNT, 2'b00};
  assign sel_mst = i_address == {ctw_pkg::CTW_IDX_MST, 2'b00};
  assign sel_wds = i_address == {ctw_pkg::CTW_IDX_WDS, 2'b00};
  assign wr_go = i_write & ack_r & i_byteenable[0];
  assign o_waitrequest = (i_read | i_write) & ~ack_r;
  assign o_readdata = rdata_r;

  // Build read data in the first cycle; unmapped reads give zero
  always_comb begin
    ack_nxt = (i_read | i_write) & ~ack_r;
    rdata_nxt = rdata_r;
    if (i_read && !ack_r) begin
      rdata_nxt = 32'h0000_0000;
      if (sel_csr) begin
        // Clear bits always read as zero
        rdata_nxt[7:0] = {ovf_r, per_r, ovfe_r, pere_r, 2'b00,
                          rate_r};
      end else if (sel_cnt) begin
        // Live counter value (see RQ17)
        rdata_nxt[7:0] = chain_r[ctw_pkg::CTW_OVF_MSB:
                                 ctw_pkg::CTW_CNT_LSB];
      end else if (sel_mst) begin
        rdata_nxt[4:0] = {stab_r, o_cpu_hold, o_wait, o_stop,
                          ~rst_n_r};
      end else if (sel_wds) begin
        // User data, not watchdog state (see RQ5)
        rdata_nxt[7:0] = ctw_pkg::CTW_SERVICE_DATA;
      end
    end
  end

  // Bus stays alive through internal reset
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Timer chain, flags and watchdog divider

  logic tick;     // Chain advances this cycle
  logic ovf_ev;   // Counter wraps from ff to 00
  logic tap_ev;   // Selected periodic tap fires
  logic stop_in;  // Entering stop this cycle
  logic csr_wr;
  logic svc;      // Watchdog service write

  assign tick = ~freeze;
  // Wrap of prescaler plus counter: bus clock / 1024 (see RQ18)
  assign ovf_ev = tick & (&chain_r[ctw_pkg::CTW_OVF_MSB:0]);
  // Taps at 2^12..2^15 bus cycles, picked by rate (see RQ19, RQ24)
  assign tap_ev = tick & (&chain_r[ctw_pkg::CTW_TAP_MSB:0])
                  & ((rate_r == 2'h0) | chain_r[12])
                  & ((rate_r < 2'h2) | chain_r[13])
                  & ((rate_r != 2'h3) | chain_r[14]);
  // Divide the tap by eight; no time-out without watchdog
  assign wd_to = P_WDOG_EN & tap_ev & (&wd_r);  // see RQ7, RQ20
  assign stop_in = (mode_r == ctw_pkg::CTW_RUN) & (mode_nxt ==
                   ctw_pkg::CTW_STOP);
  assign csr_wr = wr_go & sel_csr;
  assign svc = wr_go & sel_wds & ~i_writedata[0];  // see RQ4
  // Flags with enables request the interrupt (see RQ23)
  assign o_timer_irq = (ovf_r & ovfe_r) | (per_r & pere_r);

  // Next timer values
  always_comb begin
    // Bus clock / 4 steps the counter via the chain (see RQ17)
    chain_nxt = chain_r + {{(ctw_pkg::CTW_CHAIN_W-1){1'b0}}, tick};
    // Keeps counting in wait mode (see RQ6)
    wd_nxt = wd_r + {{(ctw_pkg::CTW_WD_W-1){1'b0}}, tap_ev};
    if (svc || !P_WDOG_EN) begin
      wd_nxt = '0;  // see RQ25
    end
    // Set wins over a clear in the same cycle (see RQ21, RQ22)
    ovf_nxt = ovf_ev | (ovf_r & ~(csr_wr &
              i_writedata[ctw_pkg::CTW_B_OVFC]));
    per_nxt = tap_ev | (per_r & ~(csr_wr &
              i_writedata[ctw_pkg::CTW_B_PERC]));
    ovfe_nxt = ovfe_r;
    pere_nxt = pere_r;
    rate_nxt = rate_r;
    if (csr_wr) begin
      ovfe_nxt = i_writedata[ctw_pkg::CTW_B_OVFE];
      pere_nxt = i_writedata[ctw_pkg::CTW_B_PERE];
      rate_nxt = i_writedata[ctw_pkg::CTW_B_RATE +: 2];
    end
    // Stop drops requests, enables and prescaler (see RQ13)
    // The cleared prescaler makes the first count after wake whole
    if (stop_in) begin
      ovf_nxt = 1'b0;
      per_nxt = 1'b0;
      ovfe_nxt = 1'b0;
      pere_nxt = 1'b0;
      chain_nxt[ctw_pkg::CTW_CNT_LSB-1:0] = '0;
    end
  end

  // Combined reset clears chain and flags (see RQ26, RQ27)
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn || !rst_n_r) begin
      chain_r <= '0;
      wd_r <= '0;  // see RQ9
      ovf_r <= 1'b0;
      per_r <= 1'b0;
      ovfe_r <= 1'b0;
      pere_r <= 1'b0;
      rate_r <= ctw_pkg::CTW_RATE_RST;
    end else begin
      chain_r <= chain_nxt;
      wd_r <= wd_nxt;
      ovf_r <= ovf_nxt;
      per_r <= per_nxt;
      ovfe_r <= ovfe_nxt;
      pere_r <= pere_nxt;
      rate_r <= rate_nxt;
    end
  end

endmodule

// >>> test/ctw_core_timer_properties.sv
// Port-level checker for the core timer, watchdog and reset logic.
// Assumes one clock domain and a synchronous active-low i_resetn.
`timescale 1ns/100ps
module ctw_core_timer_properties (
  input logic i_core_clk,
  input logic i_resetn,
  input logic i_ext_resetn,
  input logic i_low_power_reset_input_n,
  input logic i_ext_irq_n,
  input logic i_stop_req,
  input logic i_wait_req,
  input logic i_fetch_valid,
  input logic [13:0] i_fetch_addr,
  input logic o_rst_n,
  input logic o_cpu_hold,
  input logic o_clk_halt,
  input logic o_timer_irq,
  input logic o_imask_clear,
  input logic o_stop,
  input logic o_wait
);
  ////////////////////////////////////////////////////////////////////////
  logic [11:0] low_cnt_r;  // Length of the current internal reset
  logic [11:0] low_cnt_nxt;
  // Saturating count of low cycles, so long pin resets cannot wrap it
  always_comb begin
    low_cnt_nxt = low_cnt_r;
    if (!i_resetn || o_rst_n) begin
      low_cnt_nxt = 12'h000;
    end else if (low_cnt_r != 12'hfff) begin
      low_cnt_nxt = low_cnt_r + 12'h001;
    end
  end
  // Register the counter
  always_ff @(posedge i_core_clk) begin
    low_cnt_r <= low_cnt_nxt;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  // Internal causes give a 1-cycle reset; power-up, low-power and stop-exit resets stabilise
  property p_stab;
    $rose(o_rst_n) |-> (low_cnt_r >= 12'hfdf || low_cnt_r == 12'h001);
  endproperty
  a_stab: assert property (p_stab)
    else $error("reset too short");
  property p_ext;
    !i_ext_resetn [*4] |-> !o_rst_n;
  endproperty
  a_ext: assert property (p_ext)
    else $error("pin reset lost");
  property p_lp;
    !i_low_power_reset_input_n [*4] |-> !o_rst_n && o_clk_halt;
  endproperty
  a_lp: assert property (p_lp)
    else $error("low-power reset");
  property p_fetch;
    i_fetch_valid && i_fetch_addr < 14'h0020 |-> ##[1:3] !o_rst_n;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("no fetch reset");
  property p_stop_entry;
    i_stop_req && o_rst_n && !o_stop && !o_wait && !o_cpu_hold
      |=> o_stop && o_imask_clear && o_clk_halt;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop entry");
  property p_stop_quiet;
    o_stop && $past(o_stop) |-> !o_timer_irq;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("irq in stop");
  property p_stop_stay;
    (i_ext_irq_n && i_ext_resetn && i_low_power_reset_input_n) [*3]
      ##0 o_stop |=> o_stop;
  endproperty
  a_stop_stay: assert property (p_stop_stay)
    else $error("stop left");
  property p_wait_entry;
    i_wait_req && o_rst_n && !o_wait && !o_stop && !o_cpu_hold &&
      !o_timer_irq && i_ext_irq_n |=> o_wait && o_imask_clear;
  endproperty
  a_wait_entry: assert property (p_wait_entry)
    else $error("wait entry");
  property p_wait_exit;
    o_wait && o_timer_irq |-> ##[1:2] !o_wait;
  endproperty
  a_wait_exit: assert property (p_wait_exit)
    else $error("wait kept");
endmodule
bind ctw_core_timer ctw_core_timer_properties u_props (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_ext_resetn(i_ext_resetn), .i_ext_irq_n(i_ext_irq_n),
  .i_low_power_reset_input_n(i_low_power_reset_input_n),
  .i_stop_req(i_stop_req), .i_wait_req(i_wait_req),
  .i_fetch_valid(i_fetch_valid), .i_fetch_addr(i_fetch_addr),
  .o_rst_n(o_rst_n), .o_cpu_hold(o_cpu_hold), .o_clk_halt(o_clk_halt),
  .o_timer_irq(o_timer_irq), .o_imask_clear(o_imask_clear),
  .o_stop(o_stop), .o_wait(o_wait));

// >>> test/tb_ctw_core_timer.sv
// Self-checking bench for the core timer block.
// Assumes the design package and the checker are compiled first.
`timescale 1ns/100ps
module tb_ctw_core_timer;
  localparam logic [15:0] A_CSR = {ctw_pkg::CTW_IDX_CSR, 2'b00};
  localparam logic [15:0] A_CNT = {ctw_pkg::CTW_IDX_CNT, 2'b00};
  localparam logic [15:0] A_WDS = {ctw_pkg::CTW_IDX_WDS, 2'b00};
  localparam logic [15:0] A_MST = {ctw_pkg::CTW_IDX_MST, 2'b00};
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ext_resetn = 1'b1;
  logic i_low_power_reset_input_n = 1'b1;
  logic i_ext_irq_n = 1'b1;
  logic i_stop_req = 1'b0;
  logic i_wait_req = 1'b0;
  logic i_fetch_valid = 1'b0;
  logic [13:0] i_fetch_addr = 14'h0100;
  logic [15:0] i_address = 16'h0000;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic o_waitrequest, o_rst_n, o_cpu_hold, o_clk_halt;
  logic o_timer_irq, o_imask_clear, o_stop, o_wait;
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 7;
  int n;
  logic [7:0] rd, c1, k, w;
  longint t0;
  // Free-running 50 MHz clock
  always #10 i_core_clk = ~i_core_clk;
  ////////////////////////////////////////////////////////////////////////
  ctw_core_timer #(.P_WDOG_EN(1'b1)) dut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_ext_resetn(i_ext_resetn), .i_ext_irq_n(i_ext_irq_n),
    .i_low_power_reset_input_n(i_low_power_reset_input_n),
    .i_stop_req(i_stop_req), .i_wait_req(i_wait_req),
    .i_fetch_valid(i_fetch_valid), .i_fetch_addr(i_fetch_addr),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(4'hf),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_rst_n(o_rst_n), .o_cpu_hold(o_cpu_hold), .o_clk_halt(o_clk_halt),
    .o_timer_irq(o_timer_irq), .o_imask_clear(o_imask_clear),
    .o_stop(o_stop), .o_wait(o_wait));
  ////////////////////////////////////////////////////////////////////////
  // Periodic tap period in bus cycles for a rate code
  function automatic int tap(input int r);
    return 1 << (12 + r);
  endfunction
  // Control readback: flags idle, clear bits always read zero
  function automatic logic [7:0] csr_exp(input logic [7:0] v);
    return v & 8'h33;
  endfunction
  // Pick a watched output: reset, irq or wake hold
  function automatic logic pick(input int s);
    return s == 0 ? o_rst_n : (s == 1 ? o_timer_irq : o_cpu_hold);
  endfunction
  // Bounded wait; n tells how many edges it took
  task automatic wait_for(input int s, input logic lvl, input int lim);
    n = 0;
    while (pick(s) !== lvl && n < lim) begin
      @(posedge i_core_clk);
      n++;
    end
  endtask
  // One Avalon access; held until waitrequest is seen low
  task automatic acc(input bit wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_address <= a;
    i_writedata <= {24'h0, d};
    i_read <= !wr;
    i_write <= wr;
    // Only the bench watchdog ends a wait that never answers
    do begin
      @(posedge i_core_clk);
    end while (o_waitrequest !== 1'b0);
    rd = o_readdata[7:0];
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle request pulse to stop or wait
  task automatic pulse(input bit stp);
    @(posedge i_core_clk);
    i_stop_req <= stp;
    i_wait_req <= !stp;
    @(posedge i_core_clk);
    i_stop_req <= 1'b0;
    i_wait_req <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Guard against a hang; the tests need roughly 75k cycles
  initial begin
    repeat (95000) @(posedge i_core_clk);
    error_cnt++;
    give_verdict;
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    wait_for(0, 1'b1, 5000);
    chk(n >= 4064 && n < 4072, 1);
    acc(0, A_CSR, 8'h00);
    chk(rd, {6'h00, ctw_pkg::CTW_RATE_RST});
    acc(0, A_WDS, 8'h00);
    chk(rd, ctw_pkg::CTW_SERVICE_DATA);
    acc(0, 16'h0100, 8'h00);
    chk(rd, 8'h00);
    // Flags written high must not stick; every rate code is set
    for (int r = 0; r < 4; r++) begin
      w = 8'($random(seed)) | 8'hc0;
      w[1:0] = 2'(r);
      acc(1, A_CSR, w);
      acc(0, A_CSR, 8'h00);
      chk(rd, csr_exp(w));
    end
    $display("registers done");
    acc(1, A_CSR, 8'h2f);
    repeat (1030) @(posedge i_core_clk);
    chk(o_timer_irq, 1'b1);
    acc(0, A_CSR, 8'h00);
    chk(rd[7], 1'b1);
    acc(1, A_CSR, 8'h2b);
    acc(0, A_CSR, 8'h00);
    chk({rd[7], o_timer_irq}, 2'b00);
    k = 8'($random(seed)) & 8'h3f;
    acc(0, A_CNT, 8'h00);
    c1 = rd;
    // Snapshots 4k+4 cycles apart, so the count moves by k+1 exactly
    repeat (4 * k + 1) @(posedge i_core_clk);
    acc(0, A_CNT, 8'h00);
    chk(8'(rd - c1), k + 8'h01);
    $display("overflow and count done");
    // Two interrupt events a tap apart, watchdog fed meanwhile
    for (int r = 0; r < 2; r++) begin
      acc(1, A_CSR, 8'h14 | 8'(r));
      acc(1, A_WDS, 8'hfe);
      wait_for(1, 1'b1, 40000);
      t0 = $time;
      acc(1, A_CSR, 8'h14 | 8'(r));
      acc(1, A_WDS, 8'hfe);
      wait_for(1, 1'b1, 40000);
      chk(32'(($time - t0) / 20), tap(r));
    end
    $display("periodic done");
    acc(1, A_CSR, 8'h00);
    acc(1, A_WDS, 8'hfe);
    pulse(1'b0);
    @(posedge i_core_clk);
    chk(o_wait, 1'b1);
    wait_for(0, 1'b0, 40000);
    chk(n > 7 * tap(0) - 8 && n <= 8 * tap(0) + 4, 1);
    wait_for(0, 1'b1, 10);
    chk(n <= 3, 1);
    acc(0, A_CSR, 8'h00);
    chk(rd, 8'h03);
    $display("watchdog done");
    // Enable the overflow interrupt so a fresh overflow ends the wait
    acc(1, A_CSR, 8'h28);
    pulse(1'b0);
    wait_for(1, 1'b1, 2000);
    repeat (3) @(posedge i_core_clk);
    chk(o_wait, 1'b0);
    acc(1, A_WDS, 8'hfe);
    pulse(1'b1);
    @(posedge i_core_clk);
    chk({o_stop, o_timer_irq, o_clk_halt}, 3'b101);
    repeat (300) @(posedge i_core_clk);
    chk(o_stop, 1'b1);
    i_ext_irq_n <= 1'b0;
    wait_for(2, 1'b1, 10);
    i_ext_irq_n <= 1'b1;
    acc(0, A_MST, 8'h00);
    chk(rd, 8'h08);
    wait_for(2, 1'b0, 5000);
    chk(n >= 4060 && n <= 4068 && o_rst_n === 1'b1, 1);
    $display("stop done");
    @(posedge i_core_clk);
    i_fetch_addr <= 14'($random(seed)) & 14'h001f;
    i_fetch_valid <= 1'b1;
    @(posedge i_core_clk);
    i_fetch_valid <= 1'b0;
    i_fetch_addr <= 14'h0020;
    wait_for(0, 1'b0, 4);
    chk(n < 4, 1);
    wait_for(0, 1'b1, 10);
    i_fetch_valid <= 1'b1;
    @(posedge i_core_clk);
    i_fetch_valid <= 1'b0;
    wait_for(0, 1'b0, 8);
    chk(n, 8);
    $display("fetch done");
    // Reset out of stop reruns stabilisation with the chain held
    pulse(1'b1);
    i_ext_resetn <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    i_ext_resetn <= 1'b1;
    wait_for(0, 1'b1, 9000);
    chk(n >= 4064 && n < 4080 && o_stop === 1'b0, 1);
    acc(0, A_CNT, 8'h00);
    chk(rd <= 8'h01, 1);
    $display("stop reset done");
    i_ext_resetn <= 1'b0;
    i_low_power_reset_input_n <= 1'b0;
    repeat (8) @(posedge i_core_clk);
    chk({o_rst_n, o_clk_halt}, 2'b01);
    i_ext_resetn <= 1'b1;
    i_low_power_reset_input_n <= 1'b1;
    wait_for(0, 1'b1, 9000);
    chk(n >= 4064 && n < 4080, 1);
    acc(0, A_CNT, 8'h00);
    chk(rd <= 8'h01, 1);
    $display("pin reset done");
    give_verdict;
  end
endmodule
